// >>> hw/urx_chk_gen.sv
// Purpose: check-bit value for a character, shared by send and receive paths
// Assumes: data bits above the active length are zero
// Notes:   purely combinational; also says whether a check bit is present
`timescale 1ns/1ps
`include "urx_map.svh"

module urx_chk_gen (
    // character
    input  wire logic [8:0] data_i,
    input  wire logic [2:0] mode_i,
    input  wire logic       addr_i,
    // result
    output logic            chk_o,
    output logic            present_o
);
    import urx_pkg::*;

    always_comb begin
        present_o = 1'b1;
        case (mode_i)
            `URX_CHK_EVEN:  chk_o = ^data_i;
            `URX_CHK_ODD:   chk_o = ~(^data_i);
            `URX_CHK_MARK:  chk_o = 1'b1;
            `URX_CHK_SPACE: chk_o = 1'b0;
            `URX_CHK_MD0,
            `URX_CHK_MD1:   chk_o = addr_i;
            default: begin
                chk_o     = 1'b0;
                present_o = 1'b0;
            end
        endcase
    end

endmodule : urx_chk_gen

// >>> hw/urx_map.svh
// Purpose: register offsets, field positions and reset values of the serial port slice
// Assumes: APB, 32-bit data, one register per aligned word
// Notes:   check-bit mode codes follow the mode register field encoding
`ifndef URX_MAP_SVH
`define URX_MAP_SVH

`define URX_CTRL_OFF        12'h000
`define URX_MODE_OFF        12'h004
`define URX_STAT_OFF        12'h014
`define URX_RXHOLD_OFF      12'h018
`define URX_TXHOLD_OFF      12'h01C

`define URX_CR_CLRSTA_BIT   8
`define URX_CR_SENDADR_BIT  24

`define URX_MR_CHAR_LENGTH_FIELD_LSB     6
`define URX_MR_SYNC_BIT     8
`define URX_MR_CHK_LSB      9
`define URX_MR_MSB_FIRST_BIT     16
`define URX_MR_NINE_BIT     17

`define URX_SR_RXAV_BIT     0
`define URX_SR_TXRDY_BIT    1
`define URX_SR_OVR_BIT      5
`define URX_SR_CHKERR_BIT   7

`define URX_MODE_RST        32'h0000_0000

`define URX_CHK_EVEN        3'h0
`define URX_CHK_ODD         3'h1
`define URX_CHK_SPACE       3'h2
`define URX_CHK_MARK        3'h3
`define URX_CHK_NONE        3'h4
`define URX_CHK_MD0         3'h6
`define URX_CHK_MD1         3'h7

`endif

// >>> hw/urx_pkg.sv
// Purpose: types shared by the serial port slice
// Assumes: constants live in urx_map.svh
// Notes:   state codes are one-hot
package urx_pkg;

    typedef enum logic [3:0] {
        URX_IDLE = 4'b0001,
        URX_DATA = 4'b0010,
        URX_CHK  = 4'b0100,
        URX_STOP = 4'b1000
    } urx_state_e;

    typedef struct packed {
        logic [1:0] char_length_field;
        logic       nine_bit_char;
        logic       msb_first;
        logic [2:0] check_bit_mode_sel;
        logic       sync_mode;
    } urx_fmt_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } urx_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } urx_apb_rsp_s;

    typedef struct packed {
        urx_state_e  state;
        logic [3:0]  bit_cnt;
        logic [8:0]  shift;
        logic        chk_err;
        logic        done;
        logic [8:0]  data;
    } urx_rx_s;

endpackage : urx_pkg

// >>> hw/urx_top.sv
// Functional notes
// - clocked mode samples on baud clock rise
// - low sample starts character, then data bits
// - clocked mode shares asynchronous format fields
// - receiver uses transmitter length, order, check fields
// - completed character loads holding register, flags available
// - completion while available sets overrun flag
// - overrun still overwrites holding register
// - clear-status command clears overrun flag
// - six check-bit modes from mode register
// - even mode: check equals data ones parity
// - odd mode: check inverts data ones parity
// - even/odd receiver flags mismatching check bit
// - mark sends one, flags zero received
// - space sends zero, flags one received
// - disabled: no check bit, no error
// - check error sets flag, clear-status clears
// - mode codes 6 and 7 select multidrop
// - multidrop data check zero, address one
// - multidrop receiver flags high check bit
// - send-address command marks next transmit byte
// - multidrop bytes without command send zero
//
// Purpose: receive path, check-bit handling and multidrop marking of a serial port
// Assumes: APB slave on core_clk_i; baud clock and serial line come from pins
// Notes:   the async oversampler is not here; mode bit sync_mode gates the clocked receiver
`timescale 1ns/1ps
`include "urx_map.svh"

module urx_top (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  sys_rst_i,
    // apb
    input  wire urx_pkg::urx_apb_req_s apb_req_i,
    output urx_pkg::urx_apb_rsp_s      apb_rsp_o,
    // serial pins
    input  wire logic                  baud_clk_i,
    input  wire logic                  rx_line_i,
    // transmit character hand-off
    output logic [8:0]                 tx_char_o,
    output logic                       tx_chk_o,
    output logic                       tx_chk_en_o,
    output logic                       tx_char_valid_o,
    input  wire logic                  tx_char_taken_i
);
    import urx_pkg::*;

    typedef struct packed {
        logic [2:0]   bclk_sync;
        logic [1:0]   line_sync;
        urx_fmt_s     fmt;
        urx_rx_s      rx;
        logic [8:0]   rx_hold_reg;
        logic         rx_char_avail;
        logic         overrun_flag;
        logic         check_bit_error_flag;
        logic         addr_pending;
        logic [8:0]   tx_char;
        logic         tx_chk;
        logic         tx_chk_en;
        logic         tx_valid;
        urx_apb_rsp_s rsp;
    } urx_state_s;

    urx_state_s s_q;
    urx_state_s s_d;
    logic       gen_chk;
    logic       gen_present;
    logic       rx_exp_chk;
    logic       rx_has_chk;
    logic [8:0] rx_char_aligned;
    logic [8:0] tx_masked;

    // number of data bits: 5..8 from the length field, 9 when nine_bit_char
    function automatic logic [3:0] data_bits(input urx_fmt_s f);
        if (f.nine_bit_char) begin
            return 4'h9;
        end
        return 4'h5 + {2'b00, f.char_length_field};
    endfunction : data_bits

    function automatic logic is_multidrop(input logic [2:0] m);
        return (m == `URX_CHK_MD0) || (m == `URX_CHK_MD1);
    endfunction : is_multidrop

    // bits above the active length never reach the line or the check bit
    function automatic logic [8:0] mask_char(input logic [8:0] c, input urx_fmt_s f);
        logic [8:0] r;
        r = 9'h000;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(data_bits(f))) begin
                r[i] = c[i];
            end
        end
        return r;
    endfunction : mask_char

    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `URX_CTRL_OFF, `URX_MODE_OFF, `URX_STAT_OFF,
            `URX_RXHOLD_OFF, `URX_TXHOLD_OFF: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_mapped

    // multidrop reports an address through the error flag, not a fault
    function automatic logic rx_chk_error(input logic [2:0] m, input logic b, input logic e);
        if (is_multidrop(m)) begin
            return b;
        end
        return b != e;
    endfunction : rx_chk_error

    function automatic logic [31:0] stat_word(input urx_state_s st);
        logic [31:0] w;
        w                     = 32'h0000_0000;
        w[`URX_SR_RXAV_BIT]   = st.rx_char_avail;
        w[`URX_SR_TXRDY_BIT]  = ~st.tx_valid;
        w[`URX_SR_OVR_BIT]    = st.overrun_flag;
        w[`URX_SR_CHKERR_BIT] = st.check_bit_error_flag;
        return w;
    endfunction : stat_word

    // lsb-first bits arrive at the top of the shifter; realign them to bit 0
    function automatic logic [8:0] align_char(input logic [8:0] sh, input urx_fmt_s f);
        logic [8:0] r;
        logic [3:0] n;
        r = 9'h000;
        n = data_bits(f);
        if (f.msb_first) begin
            for (int i = 0; i < 9; i++) begin
                if (i < int'(n)) begin
                    r[i] = sh[i];
                end
            end
        end else begin
            for (int i = 0; i < 9; i++) begin
                if (i < int'(n)) begin
                    r[i] = sh[i + 9 - int'(n)];
                end
            end
        end
        return r;
    endfunction : align_char

    assign rx_char_aligned = align_char(s_q.rx.shift, s_q.fmt);

    // mask before the check so stray upper bits cannot flip it
    assign tx_masked = mask_char(apb_req_i.pwdata[8:0], s_q.fmt);

    urx_chk_gen u_tx_chk (
        .data_i    (tx_masked),
        .mode_i    (s_q.fmt.check_bit_mode_sel),
        .addr_i    (s_q.addr_pending),
        .chk_o     (gen_chk),
        .present_o (gen_present)
    );

    urx_chk_gen u_rx_chk (
        .data_i    (rx_char_aligned),
        .mode_i    (s_q.fmt.check_bit_mode_sel),
        .addr_i    (1'b0),
        .chk_o     (rx_exp_chk),
        .present_o (rx_has_chk)
    );

    always_comb begin
        logic       bclk_rise;
        logic       line;
        logic       acc;
        logic       wr;
        logic       rd;
        bclk_rise = 1'b0;
        line      = 1'b1;
        acc       = 1'b0;
        wr        = 1'b0;
        rd        = 1'b0;
        s_d       = s_q;

        // pin synchronisers; edge detect looks only past the first stage
        s_d.bclk_sync = {s_q.bclk_sync[1:0], baud_clk_i};
        s_d.line_sync = {s_q.line_sync[0], rx_line_i};
        bclk_rise     = s_q.bclk_sync[1] & ~s_q.bclk_sync[2];
        line          = s_q.line_sync[1];

        // apb: one wait state, pready answers in the cycle after the access
        acc = apb_req_i.psel & apb_req_i.penable;
        wr  = acc & apb_req_i.pwrite;
        rd  = acc & ~apb_req_i.pwrite;
        s_d.rsp.pready  = acc & ~s_q.rsp.pready;
        s_d.rsp.pslverr = acc & ~s_q.rsp.pready & ~is_mapped(apb_req_i.paddr);
        s_d.rsp.prdata  = 32'h0000_0000;
        wr = wr & ~s_q.rsp.pready;
        rd = rd & ~s_q.rsp.pready;

        if (rd) begin
            case (apb_req_i.paddr)
                `URX_MODE_OFF: begin
                    s_d.rsp.prdata[`URX_MR_CHAR_LENGTH_FIELD_LSB +: 2]   = s_q.fmt.char_length_field;
                    s_d.rsp.prdata[`URX_MR_SYNC_BIT]        = s_q.fmt.sync_mode;
                    s_d.rsp.prdata[`URX_MR_CHK_LSB +: 3]    = s_q.fmt.check_bit_mode_sel;
                    s_d.rsp.prdata[`URX_MR_MSB_FIRST_BIT]        = s_q.fmt.msb_first;
                    s_d.rsp.prdata[`URX_MR_NINE_BIT]        = s_q.fmt.nine_bit_char;
                end
                `URX_STAT_OFF: s_d.rsp.prdata = stat_word(s_q);
                `URX_RXHOLD_OFF: begin
                    s_d.rsp.prdata[8:0] = s_q.rx_hold_reg;
                    s_d.rx_char_avail   = 1'b0;
                end
                default: s_d.rsp.prdata = 32'h0000_0000;
            endcase
        end

        if (wr) begin
            case (apb_req_i.paddr)
                `URX_CTRL_OFF: begin
                    if (apb_req_i.pwdata[`URX_CR_CLRSTA_BIT]) begin
                        s_d.overrun_flag         = 1'b0;
                        s_d.check_bit_error_flag = 1'b0;
                    end
                    if (apb_req_i.pwdata[`URX_CR_SENDADR_BIT]) begin
                        s_d.addr_pending = 1'b1;
                    end
                end
                `URX_MODE_OFF: begin
                    // one field set serves both directions
                    s_d.fmt.char_length_field  = apb_req_i.pwdata[`URX_MR_CHAR_LENGTH_FIELD_LSB +: 2];
                    s_d.fmt.sync_mode          = apb_req_i.pwdata[`URX_MR_SYNC_BIT];
                    s_d.fmt.check_bit_mode_sel = apb_req_i.pwdata[`URX_MR_CHK_LSB +: 3];
                    s_d.fmt.msb_first          = apb_req_i.pwdata[`URX_MR_MSB_FIRST_BIT];
                    s_d.fmt.nine_bit_char      = apb_req_i.pwdata[`URX_MR_NINE_BIT];
                end
                `URX_TXHOLD_OFF: begin
                    // a write while the previous byte is still waiting replaces it
                    s_d.tx_char      = tx_masked;
                    s_d.tx_chk       = gen_chk;
                    s_d.tx_chk_en    = gen_present;
                    s_d.tx_valid     = 1'b1;
                    s_d.addr_pending = 1'b0;
                end
                default: s_d.tx_valid = s_q.tx_valid;
            endcase
        end

        if (s_q.tx_valid & tx_char_taken_i & ~(wr & (apb_req_i.paddr == `URX_TXHOLD_OFF))) begin
            s_d.tx_valid = 1'b0;
        end

        // clocked receiver, one step per baud clock rise
        s_d.rx.done = 1'b0;
        if (bclk_rise & s_q.fmt.sync_mode) begin
            case (s_q.rx.state)
                URX_IDLE: begin
                    if (!line) begin
                        s_d.rx.state   = URX_DATA;
                        s_d.rx.bit_cnt = 4'h0;
                        s_d.rx.shift   = 9'h000;
                        s_d.rx.chk_err = 1'b0;
                    end
                end
                URX_DATA: begin
                    // msb first shifts left, lsb first shifts right
                    if (s_q.fmt.msb_first) begin
                        s_d.rx.shift = {s_q.rx.shift[7:0], line};
                    end else begin
                        s_d.rx.shift = {line, s_q.rx.shift[8:1]};
                    end
                    s_d.rx.bit_cnt = s_q.rx.bit_cnt + 4'h1;
                    if (s_q.rx.bit_cnt + 4'h1 == data_bits(s_q.fmt)) begin
                        s_d.rx.state = rx_has_chk ? URX_CHK : URX_STOP;
                    end
                end
                URX_CHK: begin
                    s_d.rx.chk_err = rx_chk_error(s_q.fmt.check_bit_mode_sel, line, rx_exp_chk);
                    s_d.rx.state   = URX_STOP;
                end
                URX_STOP: begin
                    // stop bit is consumed; framing is outside this slice
                    s_d.rx.data  = rx_char_aligned;
                    s_d.rx.done  = 1'b1;
                    s_d.rx.state = URX_IDLE;
                end
                default: s_d.rx.state = URX_IDLE;
            endcase
        end

        // completion wins over a same-cycle read or clear
        if (s_q.rx.done) begin
            s_d.rx_hold_reg   = s_q.rx.data;
            s_d.rx_char_avail = 1'b1;
            if (s_q.rx_char_avail) begin
                s_d.overrun_flag = 1'b1;
            end
            if (s_q.rx.chk_err) begin
                s_d.check_bit_error_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // every field named so that none is left out of reset
            s_q.bclk_sync              <= 3'h0;
            s_q.line_sync              <= 2'h3;
            s_q.fmt.char_length_field  <= 2'h0;
            s_q.fmt.nine_bit_char      <= 1'b0;
            s_q.fmt.msb_first          <= 1'b0;
            s_q.fmt.check_bit_mode_sel <= `URX_CHK_EVEN;
            s_q.fmt.sync_mode          <= 1'b0;
            s_q.rx.state               <= URX_IDLE;
            s_q.rx.bit_cnt             <= 4'h0;
            s_q.rx.shift               <= 9'h000;
            s_q.rx.chk_err             <= 1'b0;
            s_q.rx.done                <= 1'b0;
            s_q.rx.data                <= 9'h000;
            s_q.rx_hold_reg            <= 9'h000;
            s_q.rx_char_avail          <= 1'b0;
            s_q.overrun_flag           <= 1'b0;
            s_q.check_bit_error_flag   <= 1'b0;
            s_q.addr_pending           <= 1'b0;
            s_q.tx_char                <= 9'h000;
            s_q.tx_chk                 <= 1'b0;
            s_q.tx_chk_en              <= 1'b0;
            s_q.tx_valid               <= 1'b0;
            s_q.rsp.pready             <= 1'b0;
            s_q.rsp.pslverr            <= 1'b0;
            s_q.rsp.prdata             <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp_o       = s_q.rsp;
    assign tx_char_o       = s_q.tx_char;
    assign tx_chk_o        = s_q.tx_chk;
    assign tx_chk_en_o     = s_q.tx_chk_en;
    assign tx_char_valid_o = s_q.tx_valid;

endmodule : urx_top

// >>> verification/urx_remote.sv
// Purpose: remote sender on the serial pins and local transmitter taking characters
// Assumes: one bit is eight core clocks, well under a quarter of core rate
// Notes:   baud clock stands low between frames; line idles high
`timescale 1ns/1ps

module urx_remote (
    input  wire logic core_clk_i,
    input  wire logic tx_char_valid_i,
    input  wire logic slow_i,
    output logic      baud_o,
    output logic      line_o,
    output logic      tx_char_taken_o
);
    int cnt = 0;
    initial begin
        baud_o          = 1'b0;
        line_o          = 1'b1;
        tx_char_taken_o = 1'b0;
    end
    task automatic bit_out(input logic b);
        line_o <= b;
        repeat (4) @(posedge core_clk_i);
        baud_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        baud_o <= 1'b0;
    endtask : bit_out
    task automatic send(input logic [8:0] d, input int n, input logic msb,
                        input logic has, input logic chk);
        bit_out(1'b0);
        for (int i = 0; i < n; i++)
            bit_out(msb ? d[n-1-i] : d[i]);
        if (has)
            bit_out(chk);
        bit_out(1'b1);
    endtask : send
    // slow mode holds a character several cycles before taking it
    always @(posedge core_clk_i) begin
        cnt             <= tx_char_valid_i ? cnt + 1 : 0;
        tx_char_taken_o <= tx_char_valid_i && !tx_char_taken_o && cnt >= (slow_i ? 6 : 1);
    end
endmodule : urx_remote

// >>> verification/urx_top_props.sv
// Purpose: port-level properties of the serial port slice
// Assumes: one clock; apb request taken with psel, penable high, pready low
// Notes:   check mode and pending address are shadowed from bus writes
`timescale 1ns/1ps
`include "urx_map.svh"

module urx_top_props (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  sys_rst_i,
    // apb
    input  wire urx_pkg::urx_apb_req_s apb_req_i,
    input  wire urx_pkg::urx_apb_rsp_s apb_rsp_o,
    // transmit hand-off
    input  wire logic [8:0]            tx_char_o,
    input  wire logic                  tx_chk_o,
    input  wire logic                  tx_chk_en_o,
    input  wire logic                  tx_char_valid_o,
    input  wire logic                  tx_char_taken_i
);
    import urx_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic       tk, wr, tx_w, map;
    logic [2:0] md_q;
    logic       pend_q;
    assign tk   = apb_req_i.psel && apb_req_i.penable && !apb_rsp_o.pready;
    assign wr   = tk && apb_req_i.pwrite;
    assign tx_w = wr && apb_req_i.paddr == `URX_TXHOLD_OFF;
    assign map  = apb_req_i.paddr inside {`URX_CTRL_OFF, `URX_MODE_OFF, `URX_STAT_OFF,
                                          `URX_RXHOLD_OFF, `URX_TXHOLD_OFF};
    // shadows go stale if the mode changes while a character waits
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            md_q   <= `URX_CHK_EVEN;
            pend_q <= 1'b0;
        end else begin
            if (wr && apb_req_i.paddr == `URX_MODE_OFF)
                md_q <= apb_req_i.pwdata[`URX_MR_CHK_LSB +: 3];
            if (wr && apb_req_i.paddr == `URX_CTRL_OFF && apb_req_i.pwdata[`URX_CR_SENDADR_BIT])
                pend_q <= 1'b1;
            else if (tx_w)
                pend_q <= 1'b0;
        end
    end
    one_wait_a: assert property (tk |=> apb_rsp_o.pready)
        else $error("access not answered after one wait");
    ready_pulse_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
        else $error("ready longer than one cycle");
    unmapped_err_a: assert property (tk && !map |=> apb_rsp_o.pslverr)
        else $error("unmapped access not refused");
    tx_valid_a: assert property (tx_w |=> tx_char_valid_o)
        else $error("valid missing after holding write");
    tx_taken_a: assert property (tx_char_valid_o && tx_char_taken_i && !tx_w |=> !tx_char_valid_o)
        else $error("valid kept after taken");
    chk_present_a: assert property (
        tx_char_valid_o |-> tx_chk_en_o == !(md_q inside {3'h4, 3'h5}))
        else $error("check presence wrong");
    even_chk_a: assert property (
        tx_char_valid_o && md_q == `URX_CHK_EVEN |-> tx_chk_o == ^tx_char_o)
        else $error("even check bit wrong");
    odd_chk_a: assert property (
        tx_char_valid_o && md_q == `URX_CHK_ODD |-> tx_chk_o == ~^tx_char_o)
        else $error("odd check bit wrong");
    fixed_chk_a: assert property (
        tx_char_valid_o && md_q inside {`URX_CHK_MARK, `URX_CHK_SPACE}
        |-> tx_chk_o == (md_q == `URX_CHK_MARK))
        else $error("fixed check bit wrong");
    drop_mark_a: assert property (
        tx_w && md_q[2:1] == 2'b11 |=> tx_chk_o == $past(pend_q))
        else $error("multidrop mark wrong");
endmodule : urx_top_props

bind urx_top urx_top_props u_urx_top_props (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .tx_char_o(tx_char_o), .tx_chk_o(tx_chk_o),
    .tx_chk_en_o(tx_chk_en_o), .tx_char_valid_o(tx_char_valid_o),
    .tx_char_taken_i(tx_char_taken_i));

// >>> verification/urx_top_tb.sv
// Purpose: self-checking bench for the serial port slice
// Assumes: remote model drives baud clock and line
// Notes:   every check mode is visited; check bits are corrupted at random
`timescale 1ns/1ps
`include "urx_map.svh"

module urx_top_tb;
    import urx_pkg::*;
    logic         core_clk_i = 1'b0;
    logic         sys_rst_i  = 1'b1;
    urx_apb_req_s req        = '0;
    urx_apb_rsp_s rsp;
    logic         baud, line, taken, txk, txe, txv, rerr;
    logic         slow       = 1'b0;
    logic [8:0]   txc;
    logic [31:0]  rdata;
    logic [31:0]  msk        = 32'hA1;
    int           err_count  = 0;
    int           tests_run  = 0;
    int           seed       = 73429;

    always #12.5 core_clk_i = ~core_clk_i;

    urx_top u_urx_top (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .apb_req_i(req),
        .apb_rsp_o(rsp), .baud_clk_i(baud), .rx_line_i(line), .tx_char_o(txc), .tx_chk_o(txk),
        .tx_chk_en_o(txe), .tx_char_valid_o(txv), .tx_char_taken_i(taken));
    urx_remote u_urx_remote (.core_clk_i(core_clk_i), .tx_char_valid_i(txv), .slow_i(slow),
        .baud_o(baud), .line_o(line), .tx_char_taken_o(taken));

    function automatic logic exp_chk(input logic [8:0] d, input logic [2:0] m, input logic a);
        case (m)
            `URX_CHK_EVEN: return ^d;
            `URX_CHK_ODD:  return ~^d;
            `URX_CHK_MARK: return 1'b1;
            `URX_CHK_MD0, `URX_CHK_MD1: return a;
            default:       return 1'b0;
        endcase
    endfunction : exp_chk
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge core_clk_i);
        req.penable <= 1'b1;
        do @(posedge core_clk_i); while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        rerr  = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic run_char(input int it);
        logic [2:0] m;
        logic [1:0] cl;
        logic [8:0] d;
        logic       nine, msb, bad, adr, k, ce;
        int         n;
        m    = 3'(it);
        cl   = 2'($random(seed));
        nine = (it % 5 == 4);
        msb  = 1'($random(seed));
        bad  = 1'($random(seed));
        adr  = 1'($random(seed));
        n    = nine ? 9 : 5 + int'(cl);
        d    = 9'($random(seed)) & 9'((1 << n) - 1);
        slow <= it[3];
        apb(1'b1, `URX_MODE_OFF, {14'h0, nine, msb, 4'h0, m, 1'b1, cl, 6'h0});
        if (adr)
            apb(1'b1, `URX_CTRL_OFF, 32'h1 << `URX_CR_SENDADR_BIT);
        apb(1'b1, `URX_TXHOLD_OFF, {23'h0, d});
        while (txv !== 1'b1) @(posedge core_clk_i);
        check("tx char", 32'(d), 32'(txc));
        check("tx chk", 32'(exp_chk(d, m, adr)), 32'(txk));
        check("tx chk en", 32'(m[2:1] != 2'b10), 32'(txe));
        while (txv === 1'b1) @(posedge core_clk_i);
        k  = exp_chk(d, m, adr) ^ bad;
        ce = (m[2:1] == 2'b11) ? k : (m[2:1] != 2'b10) & bad;
        u_urx_remote.send(d, n, msb, m[2:1] != 2'b10, k);
        repeat (4) @(posedge core_clk_i);
        apb(1'b0, `URX_STAT_OFF, 32'h0);
        check("status", {24'h0, ce, 7'h1}, rdata & msk);
        apb(1'b0, `URX_RXHOLD_OFF, 32'h0);
        check("rx char", 32'(d), rdata & 32'h1FF);
        apb(1'b0, `URX_STAT_OFF, 32'h0);
        check("avail cleared", {24'h0, ce, 7'h0}, rdata & msk);
        apb(1'b1, `URX_CTRL_OFF, 32'h1 << `URX_CR_CLRSTA_BIT);
        apb(1'b0, `URX_STAT_OFF, 32'h0);
        check("status cleared", 32'h0, rdata & msk);
        $display("char test %0d mode %0d done", it, m);
    endtask : run_char

    initial begin
        repeat (40000) @(posedge core_clk_i);
        err_count++;
        conclude();
    end

    initial begin
        logic [8:0] d1;
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        apb(1'b0, `URX_MODE_OFF, 32'h0);
        check("mode reset", `URX_MODE_RST, rdata);
        apb(1'b0, 12'h0F0, 32'h0);
        check("unmapped read", 32'h1, {rdata[30:0], rerr});
        apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
        check("unmapped write", 32'h1, 32'(rerr));
        $display("map test done");
        for (int it = 0; it < 40; it++)
            run_char(it);
        d1 = 9'($random(seed)) & 9'h0FF;
        apb(1'b1, `URX_MODE_OFF, {20'h0, `URX_CHK_NONE, 1'b1, 2'h3, 6'h0});
        u_urx_remote.send(d1, 8, 1'b0, 1'b0, 1'b0);
        u_urx_remote.send(~d1 & 9'h0FF, 8, 1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge core_clk_i);
        apb(1'b0, `URX_STAT_OFF, 32'h0);
        check("overrun set", 32'h21, rdata & msk);
        apb(1'b0, `URX_RXHOLD_OFF, 32'h0);
        check("overrun char", 32'(~d1 & 9'h0FF), rdata & 32'h1FF);
        apb(1'b1, `URX_CTRL_OFF, 32'h1 << `URX_CR_CLRSTA_BIT);
        apb(1'b0, `URX_STAT_OFF, 32'h0);
        check("overrun cleared", 32'h0, rdata & msk);
        $display("overrun test done");
        conclude();
    end
endmodule : urx_top_tb
